// file: shared/rxdpo_params.svh
// Constants for the E/F and G/H receive parallel output formatter
`ifndef RXDPO_PARAMS_SVH
`define RXDPO_PARAMS_SVH
`define RXDPO_BUS_W 10
`define RXDPO_LANE_W 5
`define RXDPO_RAW_W 10
`define RXDPO_BYTE_W 8
`define RXDPO_LINE_K_LO 3
`define RXDPO_LINE_B8 8
`define RXDPO_LINE_B9 9
`define RXDPO_BUS_RST 10'h000
`define RXDPO_SYNC_RST 2'h0
`endif

// file: shared/rxdpo_pkg.sv
// Types shared by the receive parallel output formatter
package rxdpo_pkg;
`include "rxdpo_params.svh"

    typedef struct packed {
        logic [`RXDPO_RAW_W-1:0] raw;
        logic [`RXDPO_BYTE_W-1:0] data;
        logic k;
    } rxdpo_chan_t;

    typedef struct packed {
        logic [`RXDPO_BUS_W-1:0] rise;
        logic [`RXDPO_BUS_W-1:0] fall;
    } rxdpo_pair_bus_t;

    typedef struct packed {
        rxdpo_pair_bus_t ef;
        rxdpo_pair_bus_t gh;
    } rxdpo_xfer_t;

    typedef enum logic [2:0] {
        RXDPO_HS_IDLE = 3'b001,
        RXDPO_HS_LOAD = 3'b010,
        RXDPO_HS_WAIT = 3'b100
    } rxdpo_hs_state_t;
endpackage

// file: hdl/rxdpo_word_cdc.sv
// Toggle handshake carrying one formatted word set into the link domain
`timescale 1ns/100ps
`include "rxdpo_params.svh"
module rxdpo_word_cdc (
    // Core side
    input wire logic src_clk,
    input wire logic src_rst_n,
    input wire logic src_ce,
    input wire logic src_load,
    input rxdpo_pkg::rxdpo_xfer_t src_data,
    output logic src_busy,
    // Link side
    input wire logic dst_clk,
    input wire logic dst_rst_n,
    input wire logic dst_ce,
    output logic dst_new,
    output rxdpo_pkg::rxdpo_xfer_t dst_data
);
    logic req_reg;
    logic [1:0] ack_sync_reg;
    logic [2:0] req_sync_reg;

    always_ff @(posedge src_clk or negedge src_rst_n)
    begin
        if (!src_rst_n)
            req_reg <= 1'b0;
        else if (src_ce && src_load)
            req_reg <= ~req_reg;
    end

    always_ff @(posedge src_clk or negedge src_rst_n)
    begin
        if (!src_rst_n)
            ack_sync_reg <= `RXDPO_SYNC_RST;
        else if (src_ce)
            ack_sync_reg <= {ack_sync_reg[0], req_sync_reg[2]};
    end

    // Source data must stay put until the toggle comes back
    assign src_busy = req_reg != ack_sync_reg[1];

    always_ff @(posedge dst_clk or negedge dst_rst_n)
    begin
        if (!dst_rst_n)
            req_sync_reg <= 3'h0;
        else if (dst_ce)
            req_sync_reg <= {req_sync_reg[1:0], req_reg};
    end

    always_ff @(posedge dst_clk or negedge dst_rst_n)
    begin
        if (!dst_rst_n)
        begin
            dst_new <= 1'b0;
            dst_data <= '0;
        end
        else if (dst_ce)
        begin
            dst_new <= req_sync_reg[2] != req_sync_reg[1];
            if (req_sync_reg[2] != req_sync_reg[1])
                dst_data <= src_data;
        end
    end
endmodule

// file: hdl/rxdpo_ddr_out.sv
// Double-data-rate launch of one ten-line receive bus
`timescale 1ns/100ps
`include "rxdpo_params.svh"
module rxdpo_ddr_out (
    // Link clock and control
    input wire logic rx_clk,
    input wire logic link_rst_n,
    input wire logic ce_l,
    // Word for the next clock period
    input wire logic load,
    input rxdpo_pkg::rxdpo_pair_bus_t pair,
    // Bus lines
    output logic [`RXDPO_BUS_W-1:0] bus
);
    rxdpo_pkg::rxdpo_pair_bus_t cur_reg;
    logic [`RXDPO_BUS_W-1:0] fall_q;
    logic [`RXDPO_BUS_W-1:0] rise_q;

    always_ff @(posedge rx_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            cur_reg <= '0;
        else if (ce_l && load)
            cur_reg <= pair;
    end

    always_ff @(negedge rx_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            fall_q <= `RXDPO_BUS_RST;
        else if (ce_l)
            fall_q <= cur_reg.fall;
    end

    always_ff @(posedge rx_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            rise_q <= `RXDPO_BUS_RST;
        else if (ce_l)
            rise_q <= cur_reg.rise;
    end

    // Output mux after two edge flops, as an output DDR cell does
    assign bus = rx_clk ? rise_q : fall_q;

    AST_DDR_FALL_THEN_RISE: assert property (
        @(posedge rx_clk) disable iff (!link_rst_n)
        load && ce_l ##1 ce_l |->
            (fall_q == $past(pair.fall)) ##1
            (rise_q == $past(pair.rise, 2)))
        else $error("ddr bus did not launch fall half then rise half");
endmodule

// file: hdl/rxdpo_top.sv
// Receive parallel output formatter for channel pairs E/F and G/H
// What this block does
// - Drive both pair buses on rising and falling receive clock edges.
// - Multiplexed mode: H on rising edge, G on falling edge of G/H bus.
// - Multiplexed mode: F on rising edge, E on falling edge of E/F bus.
// - Nibble mode: low nibble on falling edge, high nibble next rising.
// - Nibble mode: E uses E/F lines 4:0, F uses lines 9:5.
// - Nibble mode: G uses G/H lines 4:0, H uses lines 9:5.
// - Nibble mode, decoding on: line 3 is lower K flag on rising.
// - Multiplexed mode, raw: line 8 carries word bit 8.
// - Multiplexed mode, raw: line 9 carries word bit 9.
// - Multiplexed mode, decoding on: line 8 flags a K byte.
// - Nibble mode: line 8 is upper bit 3, then bit 8 or K.
// - Nibble mode, raw: line 9 is upper bit 4 then bit 9.
// - Decoding is on when the pin or management bit is set.
`timescale 1ns/100ps
`include "rxdpo_params.svh"
module rxdpo_top (
    // Core clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Link clock
    input wire logic rx_clk,
    // Received words, one set per transfer
    input wire logic word_valid,
    input rxdpo_pkg::rxdpo_chan_t word_e,
    input rxdpo_pkg::rxdpo_chan_t word_f,
    input rxdpo_pkg::rxdpo_chan_t word_g,
    input rxdpo_pkg::rxdpo_chan_t word_h,
    output logic word_ready,
    // Mode selection
    input wire logic encode_enable,
    input wire logic decode_enable_bit,
    input wire logic nibble_mode,
    // Receive buses
    output logic [`RXDPO_BUS_W-1:0] rx_bus_pair_ef,
    output logic [`RXDPO_BUS_W-1:0] rx_bus_pair_gh
);
    logic [1:0] core_rst_reg;
    logic [1:0] link_rst_reg;
    logic core_rst_n;
    logic link_rst_n;
    logic [1:0] ce_link_reg;
    logic ce_l;
    logic [1:0] enc_pin_reg;
    logic [1:0] nib_pin_reg;
    logic enc_on;
    logic nib_on;
    logic accept;
    logic cdc_busy;
    logic link_new;
    rxdpo_pkg::rxdpo_hs_state_t hs_reg;
    rxdpo_pkg::rxdpo_hs_state_t hs_next;
    rxdpo_pkg::rxdpo_xfer_t xfer_reg;
    rxdpo_pkg::rxdpo_xfer_t xfer_next;
    rxdpo_pkg::rxdpo_xfer_t link_xfer;

    // Lane of five lines: fall half in [4:0], rise half in [9:5]
    // lane bit layout
    function automatic logic [9:0] fmt_lane(
        input rxdpo_pkg::rxdpo_chan_t ch,
        input logic enc
    );
        if (enc)
            fmt_lane = {ch.data[7], ch.k, ch.data[6:4],
                1'b0, ch.data[3:0]};
        else
            fmt_lane = ch.raw;
    endfunction

    function automatic logic [9:0] fmt_word(
        input rxdpo_pkg::rxdpo_chan_t ch,
        input logic enc
    );
        if (enc)
            fmt_word = {1'b0, ch.k, ch.data};
        else
            fmt_word = ch.raw;
    endfunction

    function automatic rxdpo_pkg::rxdpo_pair_bus_t fmt_pair(
        input rxdpo_pkg::rxdpo_chan_t lo,
        input rxdpo_pkg::rxdpo_chan_t hi,
        input logic nib,
        input logic enc
    );
        rxdpo_pkg::rxdpo_pair_bus_t p;
        logic [9:0] lo_lane;
        logic [9:0] hi_lane;
        lo_lane = fmt_lane(lo, enc);
        hi_lane = fmt_lane(hi, enc);
        if (nib)
        begin
            p.fall = {hi_lane[4:0], lo_lane[4:0]};
            p.rise = {hi_lane[9:5], lo_lane[9:5]};
        end
        else
        begin
            p.fall = fmt_word(lo, enc);
            p.rise = fmt_word(hi, enc);
        end
        fmt_pair = p;
    endfunction

    // Reset release in each domain
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            core_rst_reg <= `RXDPO_SYNC_RST;
        else
            core_rst_reg <= {core_rst_reg[0], 1'b1};
    end
    assign core_rst_n = core_rst_reg[1];

    always_ff @(posedge rx_clk or negedge rst_n)
    begin
        if (!rst_n)
            link_rst_reg <= `RXDPO_SYNC_RST;
        else
            link_rst_reg <= {link_rst_reg[0], 1'b1};
    end
    assign link_rst_n = link_rst_reg[1];

    // Clock enable carried into the link domain
    always_ff @(posedge rx_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            ce_link_reg <= `RXDPO_SYNC_RST;
        else
            ce_link_reg <= {ce_link_reg[0], ce};
    end
    assign ce_l = ce_link_reg[1];

    // Pin inputs through two flops
    always_ff @(posedge clk or negedge core_rst_n)
    begin
        if (!core_rst_n)
        begin
            enc_pin_reg <= `RXDPO_SYNC_RST;
            nib_pin_reg <= `RXDPO_SYNC_RST;
        end
        else if (ce)
        begin
            enc_pin_reg <= {enc_pin_reg[0], encode_enable};
            nib_pin_reg <= {nib_pin_reg[0], nibble_mode};
        end
    end

    assign enc_on = enc_pin_reg[1] | decode_enable_bit;
    assign nib_on = nib_pin_reg[1];

    assign accept = ce && word_valid && word_ready;

    always_comb
    begin
        xfer_next.ef = fmt_pair(word_e, word_f, nib_on, enc_on);
        xfer_next.gh = fmt_pair(word_g, word_h, nib_on, enc_on);
    end

    // Word set held stable while the handshake is in flight
    always_ff @(posedge clk or negedge core_rst_n)
    begin
        if (!core_rst_n)
            xfer_reg <= '0;
        else if (accept)
            xfer_reg <= xfer_next;
    end

    always_comb
    begin
        hs_next = hs_reg;
        unique case (hs_reg)
            rxdpo_pkg::RXDPO_HS_IDLE:
                if (accept)
                    hs_next = rxdpo_pkg::RXDPO_HS_LOAD;
            rxdpo_pkg::RXDPO_HS_LOAD:
                hs_next = rxdpo_pkg::RXDPO_HS_WAIT;
            rxdpo_pkg::RXDPO_HS_WAIT:
                if (!cdc_busy)
                    hs_next = rxdpo_pkg::RXDPO_HS_IDLE;
            default:
                hs_next = rxdpo_pkg::RXDPO_HS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge core_rst_n)
    begin
        if (!core_rst_n)
            hs_reg <= rxdpo_pkg::RXDPO_HS_IDLE;
        else if (ce)
            hs_reg <= hs_next;
    end

    always_ff @(posedge clk or negedge core_rst_n)
    begin
        if (!core_rst_n)
            word_ready <= 1'b0;
        else if (ce)
            word_ready <= hs_next == rxdpo_pkg::RXDPO_HS_IDLE;
    end

    rxdpo_word_cdc u_cdc (
        .src_clk(clk),
        .src_rst_n(core_rst_n),
        .src_ce(ce),
        .src_load(hs_reg == rxdpo_pkg::RXDPO_HS_LOAD),
        .src_data(xfer_reg),
        .src_busy(cdc_busy),
        .dst_clk(rx_clk),
        .dst_rst_n(link_rst_n),
        .dst_ce(ce_l),
        .dst_new(link_new),
        .dst_data(link_xfer)
    );

    rxdpo_ddr_out u_ddr_ef (
        .rx_clk(rx_clk),
        .link_rst_n(link_rst_n),
        .ce_l(ce_l),
        .load(link_new),
        .pair(link_xfer.ef),
        .bus(rx_bus_pair_ef)
    );

    rxdpo_ddr_out u_ddr_gh (
        .rx_clk(rx_clk),
        .link_rst_n(link_rst_n),
        .ce_l(ce_l),
        .load(link_new),
        .pair(link_xfer.gh),
        .bus(rx_bus_pair_gh)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!core_rst_n);

    AST_MUX_GH_EDGES: assert property (
        accept && !nib_on && !enc_on |=>
            xfer_reg.gh.rise == $past(word_h.raw) &&
            xfer_reg.gh.fall == $past(word_g.raw))
        else $error("G/H multiplexed words on wrong edges");

    AST_MUX_EF_EDGES: assert property (
        accept && !nib_on |=>
            xfer_reg.ef.rise[7:0] ==
                ($past(enc_on) ? $past(word_f.data)
                    : $past(word_f.raw[7:0])) &&
            xfer_reg.ef.fall[7:0] ==
                ($past(enc_on) ? $past(word_e.data)
                    : $past(word_e.raw[7:0])))
        else $error("E/F multiplexed words on wrong edges");

    AST_NIB_ORDER: assert property (
        accept && nib_on && !enc_on |=>
            xfer_reg.ef.fall[4:0] == $past(word_e.raw[4:0]) &&
            xfer_reg.ef.rise[4:0] == $past(word_e.raw[9:5]))
        else $error("nibble order wrong on channel E");

    AST_NIB_EF_LANES: assert property (
        accept && nib_on && !enc_on |=>
            xfer_reg.ef.fall[9:5] == $past(word_f.raw[4:0]) &&
            xfer_reg.ef.rise[9:5] == $past(word_f.raw[9:5]))
        else $error("channel F not on lines 9:5");

    AST_NIB_GH_LANES: assert property (
        accept && nib_on && !enc_on |=>
            {xfer_reg.gh.rise, xfer_reg.gh.fall} ==
                {$past(word_h.raw[9:5]), $past(word_g.raw[9:5]),
                 $past(word_h.raw[4:0]), $past(word_g.raw[4:0])})
        else $error("G/H nibble lanes misplaced");

    AST_NIB_KFLAG_LO: assert property (
        accept && nib_on && enc_on |=>
            xfer_reg.ef.rise[`RXDPO_LINE_K_LO] == $past(word_e.k) &&
            xfer_reg.gh.rise[`RXDPO_LINE_K_LO] == $past(word_g.k))
        else $error("lower channel K flag missing on line 3");

    AST_MUX_BIT8: assert property (
        accept && !nib_on && !enc_on |=>
            xfer_reg.ef.rise[`RXDPO_LINE_B8] == $past(word_f.raw[8]) &&
            xfer_reg.ef.fall[`RXDPO_LINE_B8] == $past(word_e.raw[8]))
        else $error("line 8 does not carry raw bit 8");

    AST_MUX_BIT9: assert property (
        accept && !nib_on && !enc_on |=>
            xfer_reg.gh.rise[`RXDPO_LINE_B9] == $past(word_h.raw[9]) &&
            xfer_reg.gh.fall[`RXDPO_LINE_B9] == $past(word_g.raw[9]))
        else $error("line 9 does not carry raw bit 9");

    AST_MUX_KFLAG: assert property (
        accept && !nib_on && enc_on |=>
            xfer_reg.gh.rise[`RXDPO_LINE_B8] == $past(word_h.k) &&
            xfer_reg.gh.fall[`RXDPO_LINE_B8] == $past(word_g.k))
        else $error("line 8 is not the K flag");

    AST_NIB_LINE8: assert property (
        accept && nib_on |=>
            xfer_reg.ef.fall[`RXDPO_LINE_B8] ==
                ($past(enc_on) ? $past(word_f.data[3])
                    : $past(word_f.raw[3])) &&
            xfer_reg.ef.rise[`RXDPO_LINE_B8] ==
                ($past(enc_on) ? $past(word_f.k)
                    : $past(word_f.raw[8])))
        else $error("nibble line 8 content wrong");

    AST_NIB_LINE9: assert property (
        accept && nib_on && !enc_on |=>
            xfer_reg.gh.fall[`RXDPO_LINE_B9] == $past(word_h.raw[4]) &&
            xfer_reg.gh.rise[`RXDPO_LINE_B9] == $past(word_h.raw[9]))
        else $error("nibble line 9 content wrong");

    AST_ENC_BY_BIT: assert property (
        accept && decode_enable_bit && !nib_on |=>
            xfer_reg.ef.rise ==
                {1'b0, $past(word_f.k), $past(word_f.data)})
        else $error("management bit did not enable decoding");

    AST_READY_DROP: assert property (
        accept |=> !word_ready [*2])
        else $error("ready stayed high during a transfer");

    COV_MUX_RAW: cover property (accept && !nib_on && !enc_on);
    COV_MUX_ENC: cover property (accept && !nib_on && enc_on);
    COV_NIB_RAW: cover property (accept && nib_on && !enc_on);
    COV_NIB_ENC: cover property (accept && nib_on && enc_on);
endmodule

// file: dv/rxdpo_mac_model.sv
// Receiving protocol device that captures both halves of each bus
`timescale 1ns/100ps
`include "rxdpo_params.svh"
module rxdpo_mac_model (
    // Link clock
    input wire logic rx_clk,
    // Receive buses
    input wire logic [`RXDPO_BUS_W-1:0] bus_ef,
    input wire logic [`RXDPO_BUS_W-1:0] bus_gh,
    // Halves of the last whole period, fall half first
    output logic [`RXDPO_BUS_W-1:0] ef_fall,
    output logic [`RXDPO_BUS_W-1:0] ef_rise,
    output logic [`RXDPO_BUS_W-1:0] gh_fall,
    output logic [`RXDPO_BUS_W-1:0] gh_rise
);
    logic [`RXDPO_BUS_W-1:0] ef_hold;
    logic [`RXDPO_BUS_W-1:0] gh_hold;

    // Samples sit a quarter period after each edge, clear of the switch
    // capture falling half
    always @(negedge rx_clk)
    begin
        #30;
        ef_hold = bus_ef;
        gh_hold = bus_gh;
    end

    always @(posedge rx_clk)
    begin
        #30;
        ef_fall = ef_hold;
        gh_fall = gh_hold;
        ef_rise = bus_ef;
        gh_rise = bus_gh;
    end
endmodule

// file: dv/test_rx_ddr_parallel_output_efgh.sv
// Testbench for the E/F and G/H receive parallel output formatter
`timescale 1ns/100ps
`include "rxdpo_params.svh"
module test_rx_ddr_parallel_output_efgh;
    logic clk;
    logic rst_n;
    logic ce;
    logic rx_clk;
    logic word_valid;
    rxdpo_pkg::rxdpo_chan_t word_e, word_f, word_g, word_h;
    rxdpo_pkg::rxdpo_chan_t ca, cb, cc, cd;
    logic word_ready;
    logic encode_enable;
    logic decode_enable_bit;
    logic nibble_mode;
    logic [`RXDPO_BUS_W-1:0] rx_bus_pair_ef;
    logic [`RXDPO_BUS_W-1:0] rx_bus_pair_gh;
    logic [`RXDPO_BUS_W-1:0] ef_fall, ef_rise, gh_fall, gh_rise;
    int n_fail;
    int tests_run;

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Link clock with its own phase
    initial
    begin
        rx_clk = 1'b0;
        #7;
        forever #62.5 rx_clk = ~rx_clk;
    end

    rxdpo_top u_rxdpo_top (
        .clk(clk), .rst_n(rst_n), .ce(ce), .rx_clk(rx_clk),
        .word_valid(word_valid), .word_e(word_e), .word_f(word_f),
        .word_g(word_g), .word_h(word_h), .word_ready(word_ready),
        .encode_enable(encode_enable),
        .decode_enable_bit(decode_enable_bit), .nibble_mode(nibble_mode),
        .rx_bus_pair_ef(rx_bus_pair_ef), .rx_bus_pair_gh(rx_bus_pair_gh)
    );

    rxdpo_mac_model u_rxdpo_mac_model (
        .rx_clk(rx_clk), .bus_ef(rx_bus_pair_ef), .bus_gh(rx_bus_pair_gh),
        .ef_fall(ef_fall), .ef_rise(ef_rise),
        .gh_fall(gh_fall), .gh_rise(gh_rise)
    );

    task automatic report_and_stop;
        if (n_fail == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [9:0] exp,
                       input logic [9:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic rxdpo_pkg::rxdpo_chan_t mk(input logic [9:0] raw,
                                                  input logic [7:0] d,
                                                  input logic k);
        return {raw, d, k};
    endfunction

    // One channel's five lines for one half in nibble mode
    function automatic logic [4:0] lane(input rxdpo_pkg::rxdpo_chan_t c,
                                        input logic enc, input logic rise);
        if (enc)
            return rise ? {c.data[7], c.k, c.data[6:4]} : {1'b0, c.data[3:0]};
        return rise ? c.raw[9:5] : c.raw[4:0];
    endfunction

    function automatic logic [9:0] mux(input rxdpo_pkg::rxdpo_chan_t c,
                                       input logic enc);
        return enc ? {1'b0, c.k, c.data} : c.raw;
    endfunction

    task automatic set_mode(input logic nib, input logic enc,
                            input logic dbit);
        @(posedge clk);
        nibble_mode <= nib;
        encode_enable <= enc;
        decode_enable_bit <= dbit;
        repeat (6) @(posedge clk);
    endtask

    // Offer a set, holding it while refused, and drop it once taken
    task automatic send(input rxdpo_pkg::rxdpo_chan_t e, f, g, h);
        int i;
        i = 0;
        @(posedge clk);
        word_valid <= 1'b1;
        word_e <= e;
        word_f <= f;
        word_g <= g;
        word_h <= h;
        @(negedge clk);
        while (word_ready !== 1'b1 && i < 400)
        begin
            @(negedge clk);
            i++;
        end
        @(posedge clk);
        word_valid <= 1'b0;
        @(negedge clk);
        chk("word_ready_after_take", 10'h000, {9'h000, word_ready});
    endtask

    task automatic wait_ready;
        int i;
        i = 0;
        while (word_ready !== 1'b1 && i < 400)
        begin
            @(negedge clk);
            i++;
        end
        chk("word_ready_back", 10'h001, {9'h000, word_ready});
    endtask

    task automatic check_set(input rxdpo_pkg::rxdpo_chan_t e, f, g, h,
                             input logic nib, input logic enc);
        repeat (3) @(posedge rx_clk);
        #40;
        if (nib)
        begin
            chk("ef_fall", {lane(f, enc, 0), lane(e, enc, 0)}, ef_fall);
            chk("ef_rise", {lane(f, enc, 1), lane(e, enc, 1)}, ef_rise);
            chk("gh_fall", {lane(h, enc, 0), lane(g, enc, 0)}, gh_fall);
            chk("gh_rise", {lane(h, enc, 1), lane(g, enc, 1)}, gh_rise);
        end
        else
        begin
            chk("ef_fall", mux(e, enc), ef_fall);
            chk("ef_rise", mux(f, enc), ef_rise);
            chk("gh_fall", mux(g, enc), gh_fall);
            chk("gh_rise", mux(h, enc), gh_rise);
        end
    endtask

    task automatic run_set(input rxdpo_pkg::rxdpo_chan_t e, f, g, h,
                           input logic nib, input logic enc);
        send(e, f, g, h);
        wait_ready;
        check_set(e, f, g, h, nib, enc);
    endtask

    task automatic t_mux_raw;
        set_mode(1'b0, 1'b0, 1'b0);
        run_set(ca, cb, cc, cd, 1'b0, 1'b0);
    endtask

    task automatic t_mux_dec;
        set_mode(1'b0, 1'b1, 1'b0);
        run_set(cb, ca, cd, cc, 1'b0, 1'b1);
        set_mode(1'b0, 1'b0, 1'b1);
        run_set(ca, cb, cc, cd, 1'b0, 1'b1);
        set_mode(1'b0, 1'b1, 1'b1);
        run_set(cd, cc, cb, ca, 1'b0, 1'b1);
    endtask

    task automatic t_nib_raw;
        set_mode(1'b1, 1'b0, 1'b0);
        run_set(ca, cb, cc, cd, 1'b1, 1'b0);
        run_set(cd, cc, cb, ca, 1'b1, 1'b0);
    endtask

    task automatic t_nib_dec;
        set_mode(1'b1, 1'b1, 1'b0);
        run_set(ca, cb, cc, cd, 1'b1, 1'b1);
        set_mode(1'b1, 1'b0, 1'b1);
        run_set(cb, ca, cd, cc, 1'b1, 1'b1);
    endtask

    // Second set offered while the first is still crossing
    task automatic t_back_to_back;
        set_mode(1'b0, 1'b0, 1'b0);
        send(cc, cd, ca, cb);
        send(cb, ca, cd, cc);
        wait_ready;
        check_set(cb, ca, cd, cc, 1'b0, 1'b0);
    endtask

    // Clock enable dropped just as the set reaches the link side
    task automatic t_ce_freeze;
        set_mode(1'b0, 1'b0, 1'b0);
        send(cd, cc, cb, ca);
        @(posedge clk);
        @(posedge rx_clk);
        @(posedge clk);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        chk("word_ready_frozen", 10'h000, {9'h000, word_ready});
        ce <= 1'b1;
        wait_ready;
        repeat (2) @(posedge rx_clk);
        check_set(cd, cc, cb, ca, 1'b0, 1'b0);
    endtask

    initial
    begin
        n_fail = 0;
        tests_run = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        word_valid = 1'b0;
        word_e = '0;
        word_f = '0;
        word_g = '0;
        word_h = '0;
        encode_enable = 1'b0;
        decode_enable_bit = 1'b0;
        nibble_mode = 1'b0;
        ca = mk(10'h2a5, 8'hbc, 1'b1);
        cb = mk(10'h15a, 8'h5a, 1'b0);
        cc = mk(10'h3c3, 8'h1c, 1'b1);
        cd = mk(10'h03c, 8'hf7, 1'b0);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        t_mux_raw;
        t_mux_dec;
        t_nib_raw;
        t_nib_dec;
        t_back_to_back;
        t_ce_freeze;
        report_and_stop;
    end

    // Eleven sets need well under 40 us; this cuts a hang short
    initial
    begin
        #200000;
        n_fail++;
        report_and_stop;
    end
endmodule
